// ==== hose_adapter_model.sv ====
// adapter modules on the hoses: power-good and error lines
`timescale 1ns/1ps
module hose_adapter_model #(
    parameter int NHOSE = 4
) (
    input wire logic mclk,
    input wire logic [NHOSE-1:0] power_on,
    input wire logic [NHOSE-1:0] fault,
    input wire logic [NHOSE-1:0] hose_reset,
    output logic [NHOSE-1:0] hose_adapter_power_good,
    output logic [NHOSE-1:0] hose_adapter_error
);
    logic [NHOSE-1:0] good_reg = '0;
    logic [NHOSE-1:0] err_reg = '0;
    assign hose_adapter_power_good = good_reg;
    assign hose_adapter_error = err_reg;
    // an erroring adapter stays in error until the host sends a down-link hose reset
    always @(posedge mclk) begin
        good_reg <= power_on;
        err_reg <= (err_reg | fault) & ~hose_reset;
    end
endmodule

// ==== hose_edge_watch.sv ====
// synchronises adapter lines of all hoses and reports their events
`timescale 1ns/1ps
module hose_edge_watch #(
    parameter int NHOSE = 4
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [NHOSE-1:0] pwr_pin,
    input wire logic [NHOSE-1:0] err_pin,
    output logic [NHOSE-1:0] pwr_level,
    output logic [NHOSE-1:0] err_level,
    output logic [NHOSE-1:0] pwr_change,
    output logic [NHOSE-1:0] err_rise
);
    logic [NHOSE-1:0] p1_reg, p2_reg, p3_reg, e1_reg, e2_reg, e3_reg;
    logic [NHOSE-1:0] p1_next, p2_next, p3_next, e1_next, e2_next, e3_next;
    always_comb begin
        p1_next = pwr_pin;
        p2_next = p1_reg;
        p3_next = p2_reg;
        e1_next = err_pin;
        e2_next = e1_reg;
        e3_next = e2_reg;
    end
    // p3/e3 start from the reset value, so a line already up at reset reports once
    always_ff @(posedge mclk) begin
        if (srst) begin
            p1_reg <= '0;
            p2_reg <= '0;
            p3_reg <= '0;
            e1_reg <= '0;
            e2_reg <= '0;
            e3_reg <= '0;
        end else begin
            p1_reg <= p1_next;
            p2_reg <= p2_next;
            p3_reg <= p3_next;
            e1_reg <= e1_next;
            e2_reg <= e2_next;
            e3_reg <= e3_next;
        end
    end
    assign pwr_level = p2_reg;
    assign err_level = e2_reg;
    assign pwr_change = p2_reg ^ p3_reg;
    assign err_rise = e2_reg & ~e3_reg;
endmodule

// ==== hose_err_asserts.sv ====
// concurrent checks on the ports of the hose port error and status block
`timescale 1ns/1ps
`include "hose_err_defines.svh"
module hose_err_asserts #(
    parameter int NHOSE = 4
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire hose_err_pkg::mbox_status_t mbox_status,
    input wire logic cmd_ctrl_illogical,
    input wire logic datapath_illogical,
    input wire hose_err_pkg::irq_req_t irq_post,
    input wire logic up_link_error_command,
    input wire logic [1:0] up_link_error_hose,
    input wire logic [NHOSE-1:0] up_buf_advance,
    input wire logic system_bus_fault_line
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    logic en_reg;
    logic [2:0] off_reg;
    logic [NHOSE-1:0] tip_reg;
    // shadows of the enable and in-progress bits; off_reg counts cycles with the enable off, saturating
    always_ff @(posedge mclk) begin
        if (srst) begin
            en_reg <= 1'b0;
            off_reg <= 3'h0;
            tip_reg <= '0;
        end else begin
            if (reg_wr && reg_addr == `ADDR_CTRL) begin
                en_reg <= reg_wdata[`CTRL_IRQ_EN_BIT];
            end
            if (reg_wr && reg_addr == `ADDR_MBOX_TIP) begin
                tip_reg <= reg_wdata[NHOSE-1:0];
            end
            off_reg <= en_reg ? 3'h0 : ((off_reg == 3'h7) ? off_reg : off_reg + 3'h1);
        end
    end
    AST_ADV_MATCH: assert property (up_link_error_command |-> up_buf_advance == (NHOSE'(1) << up_link_error_hose))
        else $error("buffer advance does not match hose");
    AST_ULE_CAUSE: assert property (up_link_error_command |-> $past(mbox_status.valid)
        && $past(mbox_status.hose) == up_link_error_hose) else $error("uplink error without status packet");
    AST_ULE_MATCH: assert property (mbox_status.valid |=> up_link_error_command == !$past(tip_reg[mbox_status.hose]))
        else $error("uplink error does not follow in-progress bit");
    AST_IPL: assert property (irq_post.req |-> irq_post.ipl == `IPL_NONSPECIFIC)
        else $error("wrong interrupt level");
    AST_MBOX_IRQ: assert property (up_link_error_command |-> irq_post.req == $past(en_reg))
        else $error("interrupt does not follow enable");
    AST_IRQ_OFF: assert property (off_reg >= 3'h1 |-> !irq_post.req)
        else $error("interrupt while disabled");
    AST_FAULT_CAUSE: assert property ($rose(system_bus_fault_line) |-> $past(cmd_ctrl_illogical || datapath_illogical))
        else $error("fault without illogical state");
    AST_ILL_FAULT: assert property ((cmd_ctrl_illogical || datapath_illogical) |=> system_bus_fault_line)
        else $error("illogical state without fault");
    AST_FAULT_HOLD: assert property (system_bus_fault_line |=> system_bus_fault_line)
        else $error("fault dropped before reset");
endmodule
bind hose_port_error_status hose_err_asserts #(.NHOSE(NHOSE)) u_chk (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr,
    .mbox_status, .cmd_ctrl_illogical, .datapath_illogical, .irq_post, .up_link_error_command, .up_link_error_hose,
    .up_buf_advance, .system_bus_fault_line);

// ==== hose_err_defines.svh ====
// constants for the hose port error and status block
`ifndef HOSE_ERR_DEFINES_SVH
`define HOSE_ERR_DEFINES_SVH
`define ADDR_CMD_NSE 4'h0
`define ADDR_DP_NSE 4'h1
`define ADDR_MBOX_TIP 4'h2
`define ADDR_CTRL 4'h3
`define CTRL_IRQ_EN_BIT 0
`define CMD_UNEXP_LO 0
`define CMD_IE_BIT 4
`define CMD_IRQ_EN_BIT 5
`define DP_ERR_LO 0
`define DP_PWR_LO 4
`define DP_IE_BIT 8
`define IPL_NONSPECIFIC 5'h11
`endif

// ==== hose_err_pkg.sv ====
// types for the hose port error and status block
package hose_err_pkg;
    typedef struct packed {
        logic valid;
        logic [1:0] hose;
    } mbox_status_t;
    typedef struct packed {
        logic req;
        logic [4:0] ipl;
    } irq_req_t;
endpackage

// ==== hose_port_error_status.sv ====
// error and status reporting of a system-bus-to-hose port
// Behaviour
// - status packet without mailbox in progress flags
// - unexpected status posts level 17 if enabled
// - send up-link error, advance up buffer pointer
// - illogical state sets flag, raises bus fault
// - status holds per-hose error and power-good
// - power-good edge either way posts interrupt
// - adapter error assertion posts interrupt, deassert none
`timescale 1ns/1ps
`include "hose_err_defines.svh"
module hose_port_error_status #(
    parameter int NHOSE = 4
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire hose_err_pkg::mbox_status_t mbox_status,
    input wire logic cmd_ctrl_illogical,
    input wire logic datapath_illogical,
    input wire logic [NHOSE-1:0] hose_adapter_power_good,
    input wire logic [NHOSE-1:0] hose_adapter_error,
    output hose_err_pkg::irq_req_t irq_post,
    output logic up_link_error_command,
    output logic [1:0] up_link_error_hose,
    output logic [NHOSE-1:0] up_buf_advance,
    output logic system_bus_fault_line
);
    logic [NHOSE-1:0] unexpected_mbox_status_flag_reg, unexpected_mbox_status_flag_next;
    logic [NHOSE-1:0] mbox_in_progress_bits_reg, mbox_in_progress_bits_next;
    logic nonspecific_err_irq_enable_reg, nonspecific_err_irq_enable_next;
    logic cmd_ctrl_internal_error_flag_reg, cmd_ctrl_internal_error_flag_next;
    logic datapath_internal_error_flag_reg, datapath_internal_error_flag_next;
    logic fault_reg, fault_next;
    logic [31:0] rdata_reg, rdata_next;
    hose_err_pkg::irq_req_t irq_reg, irq_next;
    logic uplink_reg, uplink_next;
    logic [1:0] uphose_reg, uphose_next;
    logic [NHOSE-1:0] adv_reg, adv_next;
    logic [NHOSE-1:0] pwr_level, err_level, pwr_change, err_rise;
    logic [NHOSE-1:0] unexp_hit;
    logic event_any;

    hose_edge_watch #(.NHOSE(NHOSE)) u_watch (
        .mclk(mclk),
        .srst(srst),
        .pwr_pin(hose_adapter_power_good),
        .err_pin(hose_adapter_error),
        .pwr_level(pwr_level),
        .err_level(err_level),
        .pwr_change(pwr_change),
        .err_rise(err_rise)
    );

    // write-one-to-clear, with a set in the same cycle taking priority
    function automatic logic [NHOSE-1:0] w1c(input logic [NHOSE-1:0] cur, input logic [NHOSE-1:0] set,
                                              input logic [NHOSE-1:0] clr);
        w1c = set | (cur & ~clr);
    endfunction

    function automatic logic hit(input logic [3:0] a, input logic [3:0] want, input logic wr);
        hit = wr && (a == want);
    endfunction

    always_comb begin
        unexp_hit = '0;
        if (mbox_status.valid && !mbox_in_progress_bits_reg[mbox_status.hose]) begin
            unexp_hit[mbox_status.hose] = 1'b1;
        end
    end

    always_comb begin
        unexpected_mbox_status_flag_next = unexpected_mbox_status_flag_reg;
        mbox_in_progress_bits_next = mbox_in_progress_bits_reg;
        nonspecific_err_irq_enable_next = nonspecific_err_irq_enable_reg;
        cmd_ctrl_internal_error_flag_next = cmd_ctrl_internal_error_flag_reg;
        datapath_internal_error_flag_next = datapath_internal_error_flag_reg;
        // clears touch only the addressed bits; enable lives elsewhere
        if (hit(reg_addr, `ADDR_CMD_NSE, reg_wr)) begin
            unexpected_mbox_status_flag_next = w1c(unexpected_mbox_status_flag_reg, unexp_hit,
                reg_wdata[`CMD_UNEXP_LO +: NHOSE]);
            cmd_ctrl_internal_error_flag_next = cmd_ctrl_illogical |
                (cmd_ctrl_internal_error_flag_reg & ~reg_wdata[`CMD_IE_BIT]);
        end else begin
            unexpected_mbox_status_flag_next = unexpected_mbox_status_flag_reg | unexp_hit;
            cmd_ctrl_internal_error_flag_next = cmd_ctrl_internal_error_flag_reg | cmd_ctrl_illogical;
        end
        if (hit(reg_addr, `ADDR_DP_NSE, reg_wr)) begin
            datapath_internal_error_flag_next = datapath_illogical |
                (datapath_internal_error_flag_reg & ~reg_wdata[`DP_IE_BIT]);
        end else begin
            datapath_internal_error_flag_next = datapath_internal_error_flag_reg | datapath_illogical;
        end
        if (hit(reg_addr, `ADDR_MBOX_TIP, reg_wr)) begin
            mbox_in_progress_bits_next = reg_wdata[NHOSE-1:0];
        end
        if (hit(reg_addr, `ADDR_CTRL, reg_wr)) begin
            nonspecific_err_irq_enable_next = reg_wdata[`CTRL_IRQ_EN_BIT];
        end
    end

    always_comb begin
        event_any = |unexp_hit || |pwr_change || |err_rise;
        irq_next.req = nonspecific_err_irq_enable_reg && event_any;
        irq_next.ipl = `IPL_NONSPECIFIC;
        uplink_next = |unexp_hit;
        uphose_next = mbox_status.hose;
        adv_next = unexp_hit;
        // sticky until srst: only a port reset brings the arrays back
        fault_next = fault_reg | cmd_ctrl_illogical | datapath_illogical;
    end

    always_comb begin
        rdata_next = '0;
        if (reg_rd) begin
            if (reg_addr == `ADDR_CMD_NSE) begin
                rdata_next[`CMD_UNEXP_LO +: NHOSE] = unexpected_mbox_status_flag_reg;
                rdata_next[`CMD_IE_BIT] = cmd_ctrl_internal_error_flag_reg;
                rdata_next[`CMD_IRQ_EN_BIT] = nonspecific_err_irq_enable_reg;
            end else if (reg_addr == `ADDR_DP_NSE) begin
                rdata_next[`DP_ERR_LO +: NHOSE] = err_level;
                rdata_next[`DP_PWR_LO +: NHOSE] = pwr_level;
                rdata_next[`DP_IE_BIT] = datapath_internal_error_flag_reg;
            end else if (reg_addr == `ADDR_MBOX_TIP) begin
                rdata_next[NHOSE-1:0] = mbox_in_progress_bits_reg;
            end else if (reg_addr == `ADDR_CTRL) begin
                rdata_next[`CTRL_IRQ_EN_BIT] = nonspecific_err_irq_enable_reg;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            unexpected_mbox_status_flag_reg <= '0;
            mbox_in_progress_bits_reg <= '0;
            nonspecific_err_irq_enable_reg <= 1'b0;
            cmd_ctrl_internal_error_flag_reg <= 1'b0;
            datapath_internal_error_flag_reg <= 1'b0;
            fault_reg <= 1'b0;
            rdata_reg <= '0;
            irq_reg <= '0;
            uplink_reg <= 1'b0;
            uphose_reg <= '0;
            adv_reg <= '0;
        end else begin
            unexpected_mbox_status_flag_reg <= unexpected_mbox_status_flag_next;
            mbox_in_progress_bits_reg <= mbox_in_progress_bits_next;
            nonspecific_err_irq_enable_reg <= nonspecific_err_irq_enable_next;
            cmd_ctrl_internal_error_flag_reg <= cmd_ctrl_internal_error_flag_next;
            datapath_internal_error_flag_reg <= datapath_internal_error_flag_next;
            fault_reg <= fault_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
            uplink_reg <= uplink_next;
            uphose_reg <= uphose_next;
            adv_reg <= adv_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq_post = irq_reg;
    assign up_link_error_command = uplink_reg;
    assign up_link_error_hose = uphose_reg;
    assign up_buf_advance = adv_reg;
    assign system_bus_fault_line = fault_reg;
endmodule

// ==== tb.sv ====
// register-level testbench of the hose port error and status block
`timescale 1ns/1ps
module tb;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    hose_err_pkg::mbox_status_t mbox_status = '0;
    logic cmd_ctrl_illogical = 1'b0;
    logic datapath_illogical = 1'b0;
    logic [3:0] power_on = 4'h0, fault = 4'h0, hose_reset = 4'h0, hose_adapter_power_good, hose_adapter_error;
    hose_err_pkg::irq_req_t irq_post;
    logic up_link_error_command, system_bus_fault_line;
    logic [1:0] up_link_error_hose;
    logic [3:0] up_buf_advance;
    int num_errors = 0, compares = 0, cyc = 0;
    logic [31:0] irq_cnt = 32'h0;
    hose_port_error_status #(.NHOSE(4)) dut (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .mbox_status, .cmd_ctrl_illogical, .datapath_illogical, .hose_adapter_power_good, .hose_adapter_error,
        .irq_post, .up_link_error_command, .up_link_error_hose, .up_buf_advance, .system_bus_fault_line);
    hose_adapter_model #(.NHOSE(4)) adapters (.mclk, .power_on, .fault, .hose_reset, .hose_adapter_power_good,
        .hose_adapter_error);
    initial begin
        forever #20 mclk = ~mclk;
    end
    task automatic complete_run();
        if (num_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", exp, reg_rdata);
    endtask
    // the up-link pulses stand for the one cycle after the packet edge
    task automatic pulse(input logic [1:0] h, input logic [3:0] adv);
        @(posedge mclk) mbox_status <= '{valid: 1'b1, hose: h};
        @(posedge mclk) mbox_status <= '0;
        #1 chk("up_buf_advance", {28'h0, adv}, {28'h0, up_buf_advance});
        chk("up_link_error_command", {31'h0, |adv}, {31'h0, up_link_error_command});
        if (adv != 4'h0) chk("up_link_error_hose", {30'h0, h}, {30'h0, up_link_error_hose});
        @(posedge mclk);
    endtask
    task automatic pins(input logic [3:0] p, input logic [3:0] f, input logic [3:0] r, input logic [31:0] n);
        @(posedge mclk);
        power_on <= p;
        fault <= f;
        hose_reset <= r;
        repeat (8) @(posedge mclk);
        chk("irq count", n, irq_cnt);
    endtask
    // pulses are counted where they stand, one cycle each; an unknown request counts too
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (irq_post.req !== 1'b0) begin
            irq_cnt <= irq_cnt + 32'h1;
            chk("irq level", 32'h11, {27'h0, irq_post.ipl});
        end
        if (cyc == 3000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rdc(4'h0, 32'h0);
        rdc(4'h1, 32'h0);
        rdc(4'h2, 32'h0);
        rdc(4'h7, 32'h0);
        wr(4'h3, 32'h1);
        rdc(4'h3, 32'h1);
        pulse(2'h1, 4'h2);
        rdc(4'h0, 32'h22);
        chk("irq count", 32'h1, irq_cnt);
        wr(4'h2, 32'h4);
        pulse(2'h2, 4'h0);
        rdc(4'h0, 32'h22);
        chk("irq count", 32'h1, irq_cnt);
        wr(4'h3, 32'h0);
        pulse(2'h0, 4'h1);
        rdc(4'h0, 32'h3);
        chk("irq count", 32'h1, irq_cnt);
        wr(4'h0, 32'h2);
        rdc(4'h0, 32'h1);
        rdc(4'h2, 32'h4);
        wr(4'h3, 32'h1);
        pins(4'h8, 4'h0, 4'h0, 32'h2);
        rdc(4'h1, 32'h80);
        pins(4'h0, 4'h0, 4'h0, 32'h3);
        pins(4'h0, 4'h1, 4'h0, 32'h4);
        rdc(4'h1, 32'h1);
        pins(4'h0, 4'h0, 4'h1, 32'h4);
        @(posedge mclk) cmd_ctrl_illogical <= 1'b1;
        @(posedge mclk) cmd_ctrl_illogical <= 1'b0;
        #1 chk("fault line", 32'h1, {31'h0, system_bus_fault_line});
        rdc(4'h0, 32'h31);
        wr(4'h0, 32'h11);
        rdc(4'h0, 32'h20);
        @(posedge mclk) datapath_illogical <= 1'b1;
        @(posedge mclk) datapath_illogical <= 1'b0;
        rdc(4'h1, 32'h100);
        chk("fault line", 32'h1, {31'h0, system_bus_fault_line});
        @(posedge mclk) srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        #1 chk("fault line", 32'h0, {31'h0, system_bus_fault_line});
        rdc(4'h1, 32'h0);
        complete_run();
    end
endmodule
